// [verilog/hip_device.sv]
// device end of the host interface port
//
// Function
// RL1: byte selects choose bytes of long word
// RL2: select falling captures address and byte selects
// RL3: accesses start only while select asserted
// RL4: select level at reset release picks boot
// RL5: host-present boot halts until halt cleared
// RL6: read latch strobe rises on host reads
// RL7: program irq bit drives host interrupt
// RL8: bus fault or retry may interrupt host
// RL9: write latch enable driven on host writes
// RL10: ready low until access can complete
// RL11: host combines ready with latch strobes
// RL12: host drives read strobe low for reads
// RL13: write strobe rise means data latched
// RL14: host never asserts both strobes together
// RL15: two local phases from input clock
// RL16: local phases offset by quarter period
// RL17: reset sets registers, outputs inactive
// RL18: host address maps onto upper local address
// RL19: host pins synchronised before use
`timescale 1ns/10ps
module hip_device
  import hip_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host pins
  hip_link_if.dev link,
  // local memory side
  output logic [ADDR_W-1:0] local_addr_upper,
  output logic [BE_W-1:0] lcl_byte_en,
  output logic lcl_rd,
  output logic lcl_wr,
  output logic [DATA_W-1:0] lcl_wdata,
  input wire logic [DATA_W-1:0] lcl_rdata,
  input wire logic lcl_ack,
  input wire logic bus_fault_event,
  input wire logic lcl_retry,
  // program side
  input wire logic prog_irq_set,
  input wire logic prog_irq_clr,
  output logic cpu_halted,
  output logic boot_host_present
);

  ////////////////////////////////////////////////////////////////////////
  logic sel_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic wr_n_d_ff;
  logic rst_d_ff;
  logic [1:0] ph_ff;
  logic phase_a_ff;
  logic phase_b_ff;
  hip_dev_state_t state_ff;
  hip_dev_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [BE_W-1:0] be_ff;
  logic [15:0] hcl_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic strobe_ff;
  logic oe_ff;
  logic ready_ff;
  logic irq_ff;
  logic lcl_rd_ff;
  logic lcl_wr_ff;
  logic [DATA_W-1:0] lcl_wdata_ff;
  logic boot_host_ff;
  logic is_reg;
  logic wr_rise;
  logic reg_wr;

  hip_sync #(.W(3)) u_sync (
    .clk(clk),
    .din({link.host_select_n, link.host_rd_strobe_n,
          link.host_wr_strobe_n}),
    .dout({sel_n_s, rd_n_s, wr_n_s})
  ); // RL19

  ////////////////////////////////////////////////////////////////////////
  // local phases: a quarter-period apart, four clk per local period
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_ff <= PH_RST;
      phase_a_ff <= 1'b0;
      phase_b_ff <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 2'h1; // RL15
      phase_a_ff <= ph_ff[1];
      phase_b_ff <= ph_ff[1] ^ ph_ff[0]; // RL16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boot strap caught at the first edge after reset release
  always_ff @(posedge clk) begin
    rst_d_ff <= rst;
    wr_n_d_ff <= wr_n_s;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_host_ff <= 1'b0;
    end else if (rst_d_ff) begin
      boot_host_ff <= sel_n_s; // RL4
    end
  end

  assign wr_rise = wr_n_s && !wr_n_d_ff;
  assign is_reg = (addr_ff == HCL_WORD);
  assign reg_wr = (state_ff == D_WRLCL) && is_reg;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      D_IDLE: begin
        if (!sel_n_s) begin
          nxt_state = D_CAPT; // RL3
        end
      end
      D_CAPT: begin
        if (sel_n_s) begin
          nxt_state = D_IDLE;
        end else if (!rd_n_s) begin
          nxt_state = D_RDLCL;
        end else if (!wr_n_s) begin
          nxt_state = D_WRWAIT;
        end
      end
      D_RDLCL: begin
        if (is_reg || lcl_ack) begin
          nxt_state = D_RDSTB;
        end
      end
      D_RDSTB: begin
        nxt_state = D_READY;
      end
      D_WRWAIT: begin
        if (wr_rise) begin
          nxt_state = D_WRLCL; // RL13
        end
      end
      D_WRLCL: begin
        if (is_reg || lcl_ack) begin
          nxt_state = D_READY;
        end
      end
      D_READY: begin
        if (sel_n_s && rd_n_s) begin
          nxt_state = D_IDLE;
        end
      end
      default: begin
        nxt_state = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= D_IDLE; // RL17
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address and byte selects held for the whole access
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff <= '0;
      be_ff <= '0;
    end else if (state_ff == D_IDLE && !sel_n_s) begin
      addr_ff <= link.host_longword_addr; // RL2
      be_ff <= link.host_byte_lane_sel; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local bus request; register hits never reach memory
  always_ff @(posedge clk) begin
    if (rst) begin
      lcl_rd_ff <= 1'b0;
      lcl_wr_ff <= 1'b0;
      lcl_wdata_ff <= '0;
    end else begin
      lcl_rd_ff <= (nxt_state == D_RDLCL) && !is_reg && !lcl_ack;
      lcl_wr_ff <= (nxt_state == D_WRLCL) && !is_reg && !lcl_ack;
      if (state_ff == D_WRWAIT && wr_rise) begin
        lcl_wdata_ff <= link.host_wdata; // RL9
      end
    end
  end

  // write latch enable spans the local write
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= (nxt_state == D_WRLCL); // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, strobe rises one clock after data is in place
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= '0;
      strobe_ff <= 1'b0;
    end else begin
      if (state_ff == D_RDLCL && is_reg) begin
        rdata_ff <= {16'h0000, hcl_ff};
      end else if (state_ff == D_RDLCL && lcl_ack) begin
        rdata_ff <= lcl_rdata;
      end
      strobe_ff <= (state_ff == D_RDSTB) ||
                   (strobe_ff && state_ff == D_READY); // RL6
    end
  end

  // ready only once the access is complete
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == D_READY) && (state_ff != D_IDLE); // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register: hardware sets win over host clears
  always_ff @(posedge clk) begin
    if (rst) begin
      hcl_ff <= HCL_RST;
    end else begin
      if (rst_d_ff) begin
        hcl_ff[HALT_BIT] <= sel_n_s; // RL4
      end else if (reg_wr && be_ff[1] && !lcl_wdata_ff[HALT_BIT]) begin
        hcl_ff[HALT_BIT] <= 1'b0; // RL5
      end
      if (prog_irq_set) begin
        hcl_ff[IRQ_BIT] <= 1'b1; // RL7
      end else if (prog_irq_clr ||
                   (reg_wr && be_ff[0] && !lcl_wdata_ff[IRQ_BIT])) begin
        hcl_ff[IRQ_BIT] <= 1'b0;
      end
      if ((state_ff == D_RDLCL || state_ff == D_WRLCL) && !is_reg &&
          (bus_fault_event || lcl_retry)) begin
        hcl_ff[FAULT_BIT] <= 1'b1; // RL8
      end else if (reg_wr && be_ff[0] && !lcl_wdata_ff[FAULT_BIT]) begin
        hcl_ff[FAULT_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= hcl_ff[IRQ_BIT] || hcl_ff[FAULT_BIT]; // RL7 RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign link.host_rdata = rdata_ff;
  assign link.read_latch_strobe = strobe_ff;
  assign link.write_latch_oe = oe_ff;
  assign link.host_ready_out = ready_ff;
  assign link.host_irq_out = irq_ff;
  assign link.local_clock_phase_a = phase_a_ff;
  assign link.local_clock_phase_b = phase_b_ff;
  assign local_addr_upper = addr_ff; // RL18
  assign lcl_byte_en = be_ff; // RL1
  assign lcl_rd = lcl_rd_ff;
  assign lcl_wr = lcl_wr_ff;
  assign lcl_wdata = lcl_wdata_ff;
  assign cpu_halted = hcl_ff[HALT_BIT]; // RL5
  assign boot_host_present = boot_host_ff;

endmodule : hip_device

// [shared/hip_pkg.sv]
// constants, states and register layouts of the host interface port
package hip_pkg;

  localparam int ADDR_W = 27;
  localparam int BE_W = 4;
  localparam int DATA_W = 32;

  // local word address at which the host sees the host control low register
  localparam logic [ADDR_W-1:0] HCL_WORD = 27'h7FFFFF0;
  localparam int HALT_BIT = 15;
  localparam int IRQ_BIT = 1;
  localparam int FAULT_BIT = 2;
  localparam logic [15:0] HCL_RST = 16'h0000;

  // local clock phase divider: four input clocks per local period
  localparam logic [1:0] PH_RST = 2'h0;

  // controller register word offsets on the avalon side
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_ADDR = 3'h1;
  localparam logic [2:0] OFS_WDATA = 3'h2;
  localparam logic [2:0] OFS_RDATA = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_BE_LO = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_IRQ = 1;
  localparam int STAT_HALTED_SEEN = 2;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_CAPT = 3'h1,
    D_RDLCL = 3'h3,
    D_RDSTB = 3'h2,
    D_WRWAIT = 3'h6,
    D_WRLCL = 3'h7,
    D_READY = 3'h5
  } hip_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SEL = 3'h1,
    H_STRB = 3'h3,
    H_WREL = 3'h2,
    H_WAIT = 3'h6,
    H_REL = 3'h7,
    H_DRAIN = 3'h5
  } hip_host_state_t;

  // merge a bus write into a word under its byte enables
  function automatic logic [31:0] hip_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : hip_merge

endpackage : hip_pkg

// [shared/hip_link_if.sv]
// pins between the external host and the device host port
`timescale 1ns/10ps
interface hip_link_if;
  import hip_pkg::*;
  logic [ADDR_W-1:0] host_longword_addr;
  logic [BE_W-1:0] host_byte_lane_sel;
  logic host_select_n;
  logic host_rd_strobe_n;
  logic host_wr_strobe_n;
  logic [DATA_W-1:0] host_wdata;
  logic [DATA_W-1:0] host_rdata;
  logic read_latch_strobe;
  logic write_latch_oe;
  logic host_ready_out;
  logic host_irq_out;
  logic local_clock_phase_a;
  logic local_clock_phase_b;

  modport dev (
    input host_longword_addr, host_byte_lane_sel, host_select_n,
    input host_rd_strobe_n, host_wr_strobe_n, host_wdata,
    output host_rdata, read_latch_strobe, write_latch_oe,
    output host_ready_out, host_irq_out,
    output local_clock_phase_a, local_clock_phase_b
  );

  modport hst (
    output host_longword_addr, host_byte_lane_sel, host_select_n,
    output host_rd_strobe_n, host_wr_strobe_n, host_wdata,
    input host_rdata, read_latch_strobe, write_latch_oe,
    input host_ready_out, host_irq_out,
    input local_clock_phase_a, local_clock_phase_b
  );
endinterface : hip_link_if

// [verilog/hip_sync.sv]
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module hip_sync #(
  parameter int W = 3
) (
  // clock
  input wire logic clk,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // left out of reset on purpose: the boot strap must be seen at release
  always_ff @(posedge clk) begin
    meta_ff <= din;
    sync_ff <= meta_ff;
  end

  assign dout = sync_ff;
endmodule : hip_sync

// [verilog/hip_host.sv]
// host end: avalon-mm command registers driving the host port pins
`timescale 1ns/10ps
module hip_host
  import hip_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins to the device
  hip_link_if.hst link
);

  ////////////////////////////////////////////////////////////////////////
  logic rdy_s;
  logic stb_s;
  logic irq_s;
  logic stb_d_ff;
  hip_host_state_t state_ff;
  logic wait_ff;
  logic [31:0] rdat_ff;
  logic [31:0] addr_ff;
  logic [31:0] wdat_ff;
  logic [31:0] got_ff;
  logic [3:0] be_ff;
  logic dir_rd_ff;
  logic go;
  logic sel_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic data_seen_ff;

  hip_sync #(.W(3)) u_sync (
    .clk(clk),
    .din({link.host_ready_out, link.read_latch_strobe, link.host_irq_out}),
    .dout({rdy_s, stb_s, irq_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // one wait cycle, then the answer for exactly one edge
  assign go = avs_write && !wait_ff && avs_address == OFS_CTRL &&
              avs_byteenable[0] && avs_writedata[CTRL_GO] &&
              state_ff == H_IDLE;

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdat_ff <= '0;
    end else begin
      wait_ff <= !(wait_ff && (avs_read || avs_write));
      case (avs_address)
        OFS_ADDR: rdat_ff <= addr_ff;
        OFS_WDATA: rdat_ff <= wdat_ff;
        OFS_RDATA: rdat_ff <= got_ff;
        OFS_STAT: rdat_ff <= {29'h0, data_seen_ff, irq_s,
                              state_ff != H_IDLE};
        default: rdat_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff <= '0;
      wdat_ff <= '0;
      be_ff <= '0;
      dir_rd_ff <= 1'b0;
    end else if (avs_write && !wait_ff) begin
      if (avs_address == OFS_ADDR) begin
        addr_ff <= hip_merge(addr_ff, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFS_WDATA) begin
        wdat_ff <= hip_merge(wdat_ff, avs_writedata, avs_byteenable);
      end
      if (go) begin
        dir_rd_ff <= avs_writedata[CTRL_RD];
        be_ff <= avs_writedata[CTRL_BE_LO +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin sequencer; busy commands are dropped, status shows busy
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= H_IDLE;
      sel_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (go) begin
            state_ff <= H_SEL;
          end
        end
        H_SEL: begin
          sel_n_ff <= 1'b0; // RL3
          state_ff <= H_STRB;
        end
        H_STRB: begin
          rd_n_ff <= !dir_rd_ff; // RL12 RL14
          wr_n_ff <= dir_rd_ff; // RL14
          state_ff <= dir_rd_ff ? H_WAIT : H_WREL;
        end
        H_WREL: begin
          wr_n_ff <= 1'b1; // RL13
          state_ff <= H_WAIT;
        end
        H_WAIT: begin
          if (rdy_s && (!dir_rd_ff || data_seen_ff || stb_s)) begin
            state_ff <= H_REL; // RL10 RL11
          end
        end
        H_REL: begin
          sel_n_ff <= 1'b1;
          rd_n_ff <= 1'b1;
          state_ff <= H_DRAIN;
        end
        H_DRAIN: begin
          if (!rdy_s) begin
            state_ff <= H_IDLE;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // external data latch clocked by the strobe's rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      stb_d_ff <= 1'b0;
      got_ff <= '0;
      data_seen_ff <= 1'b0;
    end else begin
      stb_d_ff <= stb_s;
      if (stb_s && !stb_d_ff) begin
        got_ff <= link.host_rdata;
        data_seen_ff <= 1'b1;
      end else if (go) begin
        data_seen_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign avs_readdata = rdat_ff;
  assign avs_waitrequest = wait_ff;
  assign link.host_longword_addr = addr_ff[ADDR_W-1:0];
  assign link.host_byte_lane_sel = be_ff;
  assign link.host_select_n = sel_n_ff;
  assign link.host_rd_strobe_n = rd_n_ff;
  assign link.host_wr_strobe_n = wr_n_ff;
  assign link.host_wdata = wdat_ff;

endmodule : hip_host

// [tb/hip_monitor.sv]
// assertions on the host port pins between host end and device end
`timescale 1ns/10ps
module hip_monitor
  import hip_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host driven pins
  input wire logic host_select_n,
  input wire logic host_rd_strobe_n,
  input wire logic host_wr_strobe_n,
  // device driven pins
  input wire logic [DATA_W-1:0] host_rdata,
  input wire logic read_latch_strobe,
  input wire logic write_latch_oe,
  input wire logic host_ready_out,
  input wire logic local_clock_phase_a,
  input wire logic local_clock_phase_b
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence phase_high_s;
    local_clock_phase_a [*2];
  endsequence
  sequence phase_low_s;
    !local_clock_phase_a [*2];
  endsequence

  chk_phase_period: assert property (
    $rose(local_clock_phase_a) |-> phase_high_s ##1 phase_low_s
      ##1 local_clock_phase_a)
    else $error("phase a period is not four clocks");
  // phase b leads phase a by one clock, a quarter of the local period
  chk_phase_quarter: assert property (
    local_clock_phase_a == $past(local_clock_phase_b))
    else $error("phase a does not follow phase b by one clock");
  chk_strobes_apart: assert property (
    !(!host_rd_strobe_n && !host_wr_strobe_n))
    else $error("read and write strobes low together");
  chk_ready_needs_sel: assert property (
    $rose(host_ready_out) |-> !host_select_n)
    else $error("ready rose without host select");
  chk_strobe_on_read: assert property (
    $rose(read_latch_strobe) |->
      host_ready_out && !host_select_n && !host_rd_strobe_n)
    else $error("latch strobe rose outside a ready read");
  chk_oe_after_wrel: assert property (
    $rose(write_latch_oe) |->
      host_wr_strobe_n && host_rd_strobe_n && !host_select_n)
    else $error("write latch enable before write strobe release");
  chk_oe_write_only: assert property (
    write_latch_oe |-> !read_latch_strobe && !host_select_n)
    else $error("write latch enable outside a write");
  chk_ready_holds: assert property (
    host_ready_out && !host_select_n |=> host_ready_out)
    else $error("ready dropped while host still selects");
  chk_idle_quiet: assert property (
    host_select_n [*6] |->
      !host_ready_out && !read_latch_strobe && !write_latch_oe)
    else $error("handshake outputs active without select");
  chk_rdata_steady: assert property (
    read_latch_strobe && $past(read_latch_strobe) |-> $stable(host_rdata))
    else $error("read data moved under latch strobe");
endmodule : hip_monitor

// [tb/host_interface_port_tb.sv]
// self-checking bench: avalon host end joined to the device end
`timescale 1ns/10ps
module host_interface_port_tb;
  import hip_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [ADDR_W-1:0] local_addr_upper;
  logic [BE_W-1:0] lcl_byte_en;
  logic lcl_rd;
  logic lcl_wr;
  logic [DATA_W-1:0] lcl_wdata;
  logic [DATA_W-1:0] lcl_rdata = 32'h0;
  logic lcl_ack = 1'b0;
  logic bus_fault_event = 1'b0;
  logic lcl_retry = 1'b0;
  logic prog_irq_set = 1'b0;
  logic prog_irq_clr = 1'b0;
  logic cpu_halted;
  logic boot_host_present;
  logic [1:0] fault_sel = 2'h0;
  logic [ADDR_W-1:0] cap_addr;
  logic [BE_W-1:0] cap_be;
  logic [DATA_W-1:0] cap_wd;
  logic [31:0] rd_v;
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  hip_link_if hip_link_if_i ();
  hip_host hip_host_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(hip_link_if_i.hst));
  hip_device hip_device_i (.clk(clk), .rst(rst), .link(hip_link_if_i.dev),
    .local_addr_upper(local_addr_upper), .lcl_byte_en(lcl_byte_en),
    .lcl_rd(lcl_rd), .lcl_wr(lcl_wr), .lcl_wdata(lcl_wdata),
    .lcl_rdata(lcl_rdata), .lcl_ack(lcl_ack),
    .bus_fault_event(bus_fault_event), .lcl_retry(lcl_retry),
    .prog_irq_set(prog_irq_set), .prog_irq_clr(prog_irq_clr),
    .cpu_halted(cpu_halted), .boot_host_present(boot_host_present));
  hip_monitor hip_monitor_i (.clk(clk), .rst(rst),
    .host_select_n(hip_link_if_i.host_select_n),
    .host_rd_strobe_n(hip_link_if_i.host_rd_strobe_n),
    .host_wr_strobe_n(hip_link_if_i.host_wr_strobe_n),
    .host_rdata(hip_link_if_i.host_rdata),
    .read_latch_strobe(hip_link_if_i.read_latch_strobe),
    .write_latch_oe(hip_link_if_i.write_latch_oe),
    .host_ready_out(hip_link_if_i.host_ready_out),
    .local_clock_phase_a(hip_link_if_i.local_clock_phase_a),
    .local_clock_phase_b(hip_link_if_i.local_clock_phase_b));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pat(input logic [ADDR_W-1:0] a);
    return {5'h00, a} ^ 32'h5A5A0F0F;
  endfunction : pat

  // local memory: one-cycle ack; data inverts on each clock after the ack
  always @(posedge clk) begin
    if ((lcl_rd || lcl_wr) && !lcl_ack) begin
      lcl_ack <= 1'b1;
      lcl_rdata <= pat(local_addr_upper);
      bus_fault_event <= fault_sel[0];
      lcl_retry <= fault_sel[1];
      cap_addr <= local_addr_upper;
      cap_be <= lcl_byte_en;
      cap_wd <= lcl_wdata;
    end else begin
      lcl_ack <= 1'b0;
      bus_fault_event <= 1'b0;
      lcl_retry <= 1'b0;
      lcl_rdata <= ~lcl_rdata;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic av_cycle(input logic [2:0] a, input logic rd,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      mismatches++;
      results();
    end
  endtask : av_cycle

  // one full link transfer, waits until the host end is no longer busy
  task automatic host_op(input logic [ADDR_W-1:0] a, input logic [31:0] wd,
      input logic [3:0] be, input logic rd);
    logic [31:0] q;
    int i;
    av_cycle(OFS_ADDR, 1'b0, {5'h00, a}, 4'hF, q);
    av_cycle(OFS_WDATA, 1'b0, wd, 4'hF, q);
    av_cycle(OFS_CTRL, 1'b0, {24'h000000, be, 2'h0, rd, 1'b1}, 4'hF, q);
    for (i = 0; i < 100; i++) begin
      av_cycle(OFS_STAT, 1'b1, 32'h0, 4'hF, q);
      if (q[STAT_BUSY] === 1'b0) break;
    end
    if (i == 100) begin
      mismatches++;
      results();
    end
  endtask : host_op

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(boot_host_present, 1'b1);
    check(cpu_halted, 1'b1);
    host_op(HCL_WORD, 32'h0, 4'h3, 1'b1);
    av_cycle(OFS_RDATA, 1'b1, 32'h0, 4'hF, rd_v);
    check(rd_v[HALT_BIT], 1'b1);
    // halt lives in byte 1; byte 0 left alone
    host_op(HCL_WORD, 32'h0, 4'h2, 1'b0);
    check(cpu_halted, 1'b0);
    host_op(27'h0123456, 32'hCAFE1234, 4'hA, 1'b0);
    check(cap_addr, 27'h0123456);
    check(cap_be, 4'hA);
    check(cap_wd, 32'hCAFE1234);
    host_op(27'h2ABCDEF, 32'h0, 4'h5, 1'b1);
    av_cycle(OFS_RDATA, 1'b1, 32'h0, 4'hF, rd_v);
    check(rd_v, pat(27'h2ABCDEF));
    check(cap_addr, 27'h2ABCDEF);
    check(cap_be, 4'h5);
    av_cycle(OFS_STAT, 1'b1, 32'h0, 4'hF, rd_v);
    check(rd_v[STAT_HALTED_SEEN], 1'b1);
    @(posedge clk);
    prog_irq_set <= 1'b1;
    @(posedge clk);
    prog_irq_set <= 1'b0;
    repeat (3) @(posedge clk);
    check(hip_link_if_i.host_irq_out, 1'b1);
    av_cycle(OFS_STAT, 1'b1, 32'h0, 4'hF, rd_v);
    check(rd_v[STAT_IRQ], 1'b1);
    prog_irq_clr <= 1'b1;
    @(posedge clk);
    prog_irq_clr <= 1'b0;
    repeat (3) @(posedge clk);
    check(hip_link_if_i.host_irq_out, 1'b0);
    // fault then retry, each cleared by a host write of zero
    for (int k = 1; k < 3; k++) begin
      fault_sel <= k[1:0];
      host_op(27'h0000040, 32'h0, 4'hF, 1'b1);
      fault_sel <= 2'h0;
      repeat (3) @(posedge clk);
      check(hip_link_if_i.host_irq_out, 1'b1);
      host_op(HCL_WORD, 32'h0, 4'h1, 1'b0);
      repeat (3) @(posedge clk);
      check(hip_link_if_i.host_irq_out, 1'b0);
    end
    results();
  end
endmodule : host_interface_port_tb
